// ---- core/wdpc_top.sv ----
// Watchdog timer and halt/stop power-down control behind an AXI4-Lite slave
// Operation
// - Watchdog is a retriggerable 16-bit one-shot resetting at terminal count.
// - Counter advances once per 64 oscillator clocks, once per 256 for select 111.
// - Timeout in run or halt vectors to 0020H and sets watchdog flag.
// - Timeout select resets to 001, shortest timeout, watchdog enabled.
// - Refresh instruction reloads the count from the timeout select.
// - Upper five control bits writable only during first instruction after reset.
// - Watchdog disableable only at first instruction; stopped in stop mode.
// - Timeout and refresh in same cycle: timeout wins.
// - Reset clears both flags; timeout and stop instruction set them.
// - Reading flags leaves them; software clears each by a write.
// - Select 000 disables; 001..111 give the listed crystal clock timeouts.
// - Bit 7 keeps watchdog active in halt; reset value is 1.
// - Bit 3 resets set; set makes stop a no-op, clear enables stop.
// - Halt opcode 7F gates CPU clock, oscillator keeps running.
// - Interrupt leaves halt; execution resumes after the halt instruction.
// - Timeout leaving halt restarts execution at 0020H.
// - Stop opcode 6F turns oscillator and system clock off.
// - Stop ends only by power-on reset or recovery, restarting at 0020H.
// - Low recovery pin ends stop; restart follows the power-on delay.
// - Recovery from stop keeps the control registers unchanged.
//
// Implementation choice: the AXI4-Lite slave port.
`include "wdpc_defines.svh"
module wdpc_top #(
   parameter int unsigned PRESCALE       = `WDPC_PRESCALE,
   parameter logic [7:0]  REFRESH_OPCODE = `WDPC_OP_REFRESH,
   parameter int unsigned POR_DELAY_NS   = `WDPC_POR_DELAY_NS
) (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic                    ce,
   input  wire logic [`WDPC_ADDR_W-1:0] awaddr,
   input  wire logic                    awvalid,
   output logic                         awready,
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output logic                         wready,
   output logic [1:0]                   bresp,
   output logic                         bvalid,
   input  wire logic                    bready,
   input  wire logic [`WDPC_ADDR_W-1:0] araddr,
   input  wire logic                    arvalid,
   output logic                         arready,
   output logic [31:0]                  rdata,
   output logic [1:0]                   rresp,
   output logic                         rvalid,
   input  wire logic                    rready,
   input  wire logic                    instr_valid,
   input  wire logic [7:0]              instr_opcode,
   input  wire logic                    irq_req,
   input  wire logic                    osc_tick,
   input  wire logic                    recovery_input_pin,
   output logic                         restart_req,
   output logic [15:0]                  restart_addr,
   output logic                         cpu_clk_en,
   output logic                         osc_en
);
   localparam int unsigned AW      = `WDPC_ADDR_W;
   localparam int unsigned POR_RAW = (POR_DELAY_NS + `WDPC_CLK_NS - 1) / `WDPC_CLK_NS;
   localparam int unsigned POR_CYC = (POR_RAW < 1) ? 1 : POR_RAW;
   localparam int unsigned PW      = $clog2(POR_CYC + 1);

   function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] idx);
      hit = a[AW-1:2] == (AW-2)'(idx);
   endfunction : hit

   wdpc_cnt_if cnt_bus ();

   wdpc_pkg::wdpc_state_e state;
   wdpc_pkg::wdpc_state_e next_state;
   logic [7:0]            ctrl;
   logic [1:0]            flags;
   logic                  first_win;
   logic [PW-1:0]         por_cnt;
   logic                  aw_held;
   logic                  w_held;
   logic [AW-1:0]         aw_addr_q;
   logic [7:0]            w_data_q;
   logic                  w_strb_q;

   // Write side decode
   wire        wr_fire  = aw_held && w_held && !bvalid;
   wire        wr_ctrl  = wr_fire && hit(aw_addr_q, `WDPC_IDX_CTRL);
   wire        wr_stat  = wr_fire && hit(aw_addr_q, `WDPC_IDX_STAT) && w_strb_q;
   wire        wr_map   = hit(aw_addr_q, `WDPC_IDX_CTRL) || hit(aw_addr_q, `WDPC_IDX_STAT)
                          || hit(aw_addr_q, `WDPC_IDX_CNT_LO) || hit(aw_addr_q, `WDPC_IDX_CNT_HI);
   wire        ctrl_ok  = wr_ctrl && w_strb_q && first_win;
   wire [7:0]  next_ctrl = (ctrl & ~`WDPC_CTRL_WMASK) | (w_data_q & `WDPC_CTRL_WMASK);

   // Read side decode
   wire        rd_fire  = arvalid && arready;
   wire [7:0]  stat_byte = {3'h0, state, first_win, flags};
   wire        rd_lo    = hit(araddr, `WDPC_IDX_CNT_LO);
   wire        rd_hi    = hit(araddr, `WDPC_IDX_CNT_HI);
   wire        rd_ctrl  = hit(araddr, `WDPC_IDX_CTRL);
   wire        rd_stat  = hit(araddr, `WDPC_IDX_STAT);
   wire        rd_map   = rd_lo || rd_hi || rd_ctrl || rd_stat;
   wire [7:0]  rd_byte  = rd_lo   ? cnt_bus.count[7:0]  :
                          rd_hi   ? cnt_bus.count[15:8] :
                          rd_ctrl ? ctrl                :
                          rd_stat ? stat_byte           : 8'h00;

   // Instruction decode, only while the core executes
   wire        in_run     = instr_valid && state == wdpc_pkg::st_run;
   wire        wd_hit     = cnt_bus.timeout && (state == wdpc_pkg::st_run || state == wdpc_pkg::st_halt);
   wire        op_halt    = in_run && instr_opcode == `WDPC_OP_HALT && !wd_hit;
   wire        op_stop    = in_run && instr_opcode == `WDPC_OP_STOP && !wd_hit;
   wire        op_refresh = in_run && instr_opcode == REFRESH_OPCODE;
   wire        stop_dis   = ctrl[`WDPC_STOPDIS_BIT];
   // stop is a no-op when disabled
   wire        enter_stop = op_stop && !stop_dis;
   wire        recov_req  = state == wdpc_pkg::st_stop && !recovery_input_pin;
   wire        rec_done   = state == wdpc_pkg::st_recov && por_cnt == '0;
   wire [1:0]  flag_set;
   wire [1:0]  flag_clr   = wr_stat ? w_data_q[1:0] : 2'h0;

   assign flag_set[`WDPC_FLAG_WD] = wd_hit;
   assign flag_set[`WDPC_FLAG_SR] = enter_stop;

   assign cnt_bus.tick    = osc_tick;
   assign cnt_bus.sel     = ctrl[`WDPC_SEL_HI:`WDPC_SEL_LO];
   assign cnt_bus.run     = cnt_bus.sel != `WDPC_SEL_OFF && (state == wdpc_pkg::st_run
                            || (state == wdpc_pkg::st_halt && ctrl[`WDPC_HALT_BIT]));
   assign cnt_bus.refresh = op_refresh || ctrl_ok || rec_done;

   wdpc_count #(
      .PRESCALE (PRESCALE)
   ) u_count (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .c       (cnt_bus)
   );

   always_comb begin
      next_state = state;
      case (state)
         wdpc_pkg::st_run: begin
            if (enter_stop) begin
               next_state = wdpc_pkg::st_stop;
            end else if (op_halt) begin
               next_state = wdpc_pkg::st_halt;
            end
         end
         wdpc_pkg::st_halt: begin
            if (wd_hit || irq_req) begin
               next_state = wdpc_pkg::st_run;
            end
         end
         wdpc_pkg::st_stop: begin
            if (recov_req) begin
               next_state = wdpc_pkg::st_recov;
            end
         end
         wdpc_pkg::st_recov: begin
            if (rec_done) begin
               next_state = wdpc_pkg::st_run;
            end
         end
         default: next_state = wdpc_pkg::st_run;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state        <= wdpc_pkg::st_run;
         cpu_clk_en   <= 1'b1;
         osc_en       <= 1'b1;
         restart_req  <= 1'b0;
         restart_addr <= `WDPC_RESTART;
      end else if (ce) begin
         state        <= next_state;
         cpu_clk_en   <= next_state == wdpc_pkg::st_run;
         osc_en       <= next_state != wdpc_pkg::st_stop;
         restart_req  <= wd_hit || rec_done;
      end
   end

   // Power-on delay between wake and restart; oscillator settles meanwhile
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         por_cnt <= '0;
      end else if (ce) begin
         if (recov_req) begin
            por_cnt <= PW'(POR_CYC - 1);
         end else if (state == wdpc_pkg::st_recov && por_cnt != '0) begin
            por_cnt <= por_cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl      <= `WDPC_CTRL_RST;
         first_win <= 1'b1;
      end else if (ce) begin
         if (ctrl_ok) begin
            ctrl <= next_ctrl;
         end
         if (instr_valid) begin
            first_win <= 1'b0;
         end
      end
   end

   for (genvar gi = 0; gi < 2; gi++) begin : g_flag
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            flags[gi] <= 1'b0;
         end else if (ce) begin
            if (flag_set[gi]) begin
               flags[gi] <= 1'b1;
            end else if (flag_clr[gi]) begin
               flags[gi] <= 1'b0;
            end
         end
      end
   end

   // Write channels: one write in flight, address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b1;
         wready    <= 1'b1;
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         aw_addr_q <= '0;
         w_data_q  <= 8'h00;
         w_strb_q  <= 1'b0;
         bvalid    <= 1'b0;
         bresp     <= `WDPC_RESP_OK;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_held   <= 1'b1;
            aw_addr_q <= awaddr;
            awready   <= 1'b0;
         end
         if (wvalid && wready) begin
            w_held   <= 1'b1;
            w_data_q <= wdata[7:0];
            w_strb_q <= wstrb[0];
            wready   <= 1'b0;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= wr_map ? `WDPC_RESP_OK : `WDPC_RESP_ERR;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // Read channel; the two count bytes are not captured together
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `WDPC_RESP_OK;
      end else if (ce) begin
         if (rd_fire) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rd_byte};
            rresp   <= rd_map ? `WDPC_RESP_OK : `WDPC_RESP_ERR;
         end
         if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_wake;
      ce && state == wdpc_pkg::st_stop && !recovery_input_pin;
   endsequence
   sequence s_delay;
      state == wdpc_pkg::st_recov && osc_en && !cpu_clk_en;
   endsequence

   timeout_vector_a: assert property (ce && wd_hit |=> restart_req && flags[0] && restart_addr == `WDPC_RESTART)
      else $error("timeout did not vector and flag");
   halt_timeout_a: assert property (ce && wd_hit && state == wdpc_pkg::st_halt |=> state == wdpc_pkg::st_run)
      else $error("timeout did not leave halt");
   win_lock_a: assert property (ce && !first_win && wr_ctrl |=> $stable(ctrl))
      else $error("control changed after first instruction");
   ctrl_reset_a: assert property ($rose(aresetn) |-> ctrl == `WDPC_CTRL_RST && first_win)
      else $error("control reset value wrong");
   flags_reset_a: assert property ($rose(aresetn) |-> flags == 2'h0)
      else $error("flags not cleared by reset");
   read_keep_a: assert property (ce && rd_fire && !wr_stat && flag_set == 2'h0 |=> $stable(flags))
      else $error("read disturbed the flags");
   halt_quiet_a: assert property (state == wdpc_pkg::st_halt && !ctrl[`WDPC_HALT_BIT] |-> !cnt_bus.run)
      else $error("watchdog ran in halt while disabled");
   stop_nop_a: assert property (ce && op_stop && stop_dis |=> state == wdpc_pkg::st_run)
      else $error("stop entered while disabled");
   stop_enter_a: assert property (ce && enter_stop |=> state == wdpc_pkg::st_stop && !osc_en && flags[1])
      else $error("stop not entered");
   halt_gate_a: assert property (state == wdpc_pkg::st_halt |-> !cpu_clk_en && osc_en)
      else $error("halt clock gating wrong");
   stop_frozen_a: assert property (state == wdpc_pkg::st_stop |-> !cnt_bus.run && !restart_req)
      else $error("watchdog active in stop");
   recov_enter_a: assert property (s_wake |=> s_delay)
      else $error("recovery pin did not wake");
   recov_restart_a: assert property (ce && rec_done |=> restart_req && cpu_clk_en && flags[1])
      else $error("no restart after recovery");
endmodule : wdpc_top

// ---- core/wdpc_defines.svh ----
// Register indices, field positions, opcodes and timing constants of the watchdog block
`ifndef WDPC_DEFINES_SVH
`define WDPC_DEFINES_SVH
`define WDPC_ADDR_W        12
`define WDPC_IDX_CNT_LO    8'hC2
`define WDPC_IDX_CNT_HI    8'hC3
`define WDPC_IDX_CTRL      8'hC4
`define WDPC_IDX_STAT      8'hC5
`define WDPC_CTRL_RST      8'h98
`define WDPC_CTRL_WMASK    8'hF8
`define WDPC_HALT_BIT      7
`define WDPC_SEL_HI        6
`define WDPC_SEL_LO        4
`define WDPC_STOPDIS_BIT   3
`define WDPC_SEL_RST       3'h1
`define WDPC_SEL_OFF       3'h0
`define WDPC_FLAG_WD       0
`define WDPC_FLAG_SR       1
`define WDPC_OP_HALT       8'h7F
`define WDPC_OP_STOP       8'h6F
`define WDPC_OP_REFRESH    8'h5F
`define WDPC_RESTART       16'h0020
`define WDPC_PRESCALE      64
`define WDPC_LONG_MULT     4
`define WDPC_TPC_1         32'd65536
`define WDPC_TPC_2         32'd131072
`define WDPC_TPC_3         32'd262144
`define WDPC_TPC_4         32'd524288
`define WDPC_TPC_5         32'd1048576
`define WDPC_TPC_6         32'd2097152
`define WDPC_TPC_7         32'd8388608
`define WDPC_CLK_NS        25
`define WDPC_POR_DELAY_NS  400
`define WDPC_RESP_OK       2'h0
`define WDPC_RESP_ERR      2'h2
`endif

// ---- core/wdpc_pkg.sv ----
// Types shared by the watchdog and power-down control modules
package wdpc_pkg;
   typedef enum logic [1:0] {
      st_run   = 2'h0,
      st_stop  = 2'h1,
      st_recov = 2'h3,
      st_halt  = 2'h2
   } wdpc_state_e;
   typedef logic [2:0] wdpc_sel_t;
endpackage : wdpc_pkg

// ---- core/wdpc_cnt_if.sv ----
// Link between the power-down control and the watchdog counter
interface wdpc_cnt_if;
   logic                tick;
   logic                run;
   logic                refresh;
   wdpc_pkg::wdpc_sel_t sel;
   logic [15:0]         count;
   logic                timeout;
   modport ctl (output tick, output run, output refresh, output sel, input count, input timeout);
   modport cnt (input tick, input run, input refresh, input sel, output count, output timeout);
endinterface : wdpc_cnt_if

// ---- core/wdpc_count.sv ----
// Prescaled 16-bit watchdog down counter
`include "wdpc_defines.svh"
module wdpc_count #(
   parameter int unsigned PRESCALE = `WDPC_PRESCALE
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   wdpc_cnt_if.cnt  c
);
   localparam int unsigned PW = $clog2(PRESCALE * `WDPC_LONG_MULT);

   function automatic logic [15:0] load_of(input wdpc_pkg::wdpc_sel_t s);
      case (s)
         3'h1:    load_of = 16'(`WDPC_TPC_1 / `WDPC_PRESCALE);
         3'h2:    load_of = 16'(`WDPC_TPC_2 / `WDPC_PRESCALE);
         3'h3:    load_of = 16'(`WDPC_TPC_3 / `WDPC_PRESCALE);
         3'h4:    load_of = 16'(`WDPC_TPC_4 / `WDPC_PRESCALE);
         3'h5:    load_of = 16'(`WDPC_TPC_5 / `WDPC_PRESCALE);
         3'h6:    load_of = 16'(`WDPC_TPC_6 / `WDPC_PRESCALE);
         3'h7:    load_of = 16'(`WDPC_TPC_7 / (`WDPC_PRESCALE * `WDPC_LONG_MULT));
         default: load_of = 16'h0000;
      endcase
   endfunction : load_of

   logic [PW-1:0] pre;
   logic [15:0]   cnt_q;
   logic          timeout_q;
   // Longest code would overflow 16 bits, so its prescaler runs four times longer
   wire  [PW-1:0] pre_lim  = (c.sel == 3'h7) ? PW'(PRESCALE * `WDPC_LONG_MULT - 1) : PW'(PRESCALE - 1);
   wire           last_pre = pre == pre_lim;
   wire           expire   = c.run && c.tick && last_pre && cnt_q == 16'h0001;

   assign c.count   = cnt_q;
   assign c.timeout = timeout_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre       <= '0;
         cnt_q     <= load_of(`WDPC_SEL_RST);
         timeout_q <= 1'b0;
      end else if (ce) begin
         timeout_q <= expire;
         if (c.refresh || expire) begin
            pre   <= '0;
            cnt_q <= load_of(c.sel);
         end else if (c.run && c.tick) begin
            pre <= last_pre ? '0 : pre + 1'b1;
            if (last_pre) begin
               cnt_q <= cnt_q - 16'h0001;
            end
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   refresh_load_a: assert property (ce && c.refresh && !expire |=> cnt_q == load_of($past(c.sel)) && pre == '0)
      else $error("refresh did not reload the count");
   timeout_wins_a: assert property (ce && c.refresh && expire |=> timeout_q)
      else $error("refresh masked a timeout");
   prescale_hold_a: assert property (ce && c.run && c.tick && !last_pre && !c.refresh |=> $stable(cnt_q))
      else $error("count moved before prescaler wrapped");
endmodule : wdpc_count

// ---- tb/wdpc_core_model.sv ----
// Processor core model: instructions, interrupt request, oscillator ticks, recovery pin
module wdpc_core_model #(
   parameter int RPM = 4
) (
   input  wire logic  aclk,
   input  wire logic  cpu_clk_en,
   input  wire logic  osc_en,
   output logic       instr_valid,
   output logic [7:0] instr_opcode,
   output logic       irq_req,
   output logic       osc_tick,
   output logic       recovery_input_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      instr_valid = 1'b0;
      instr_opcode = 8'h00;
      irq_req = 1'b0;
      osc_tick = 1'b0;
      recovery_input_pin = 1'b1;
   end
   always @(posedge aclk) begin
      osc_tick <= osc_en;
   end
   task automatic exec(input logic [7:0] op);
      int t;
      @(posedge aclk);
      for (t = 0; t < 100 && cpu_clk_en !== 1'b1; t++) @(posedge aclk);
      instr_valid  <= 1'b1;
      instr_opcode <= op;
      @(posedge aclk);
      instr_valid <= 1'b0;
   endtask : exec
   task automatic irq();
      int t;
      @(posedge aclk);
      irq_req <= 1'b1;
      for (t = 0; t < 100 && cpu_clk_en !== 1'b1; t++) @(posedge aclk);
      irq_req <= 1'b0;
   endtask : irq
   // low for the minimum pulse width
   task automatic wake();
      @(posedge aclk);
      recovery_input_pin <= 1'b0;
      repeat (RPM) @(posedge aclk);
      recovery_input_pin <= 1'b1;
   endtask : wake
endmodule : wdpc_core_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the watchdog and power-down block
`include "wdpc_defines.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P = 2;
   localparam int TO1 = `WDPC_TPC_1 / `WDPC_PRESCALE * P;
   localparam logic [11:0] A_CTRL = {2'h0, `WDPC_IDX_CTRL, 2'h0};
   localparam logic [11:0] A_STAT = {2'h0, `WDPC_IDX_STAT, 2'h0};
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0]  wstrb = 0;
   logic [1:0]  bresp, rresp, rsp;
   logic        awready, wready, bvalid, arready, rvalid, restart_req, cpu_clk_en, osc_en;
   logic        instr_valid, irq_req, osc_tick, recovery_input_pin;
   logic [7:0]  instr_opcode;
   logic [15:0] restart_addr;
   logic        ce = 1'b1;
   logic [31:0] d;
   int          mismatches = 0, n_compared = 0;
   wdpc_top #(.PRESCALE(P), .POR_DELAY_NS(25)) u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
      .irq_req(irq_req), .osc_tick(osc_tick), .recovery_input_pin(recovery_input_pin),
      .restart_req(restart_req), .restart_addr(restart_addr), .cpu_clk_en(cpu_clk_en), .osc_en(osc_en));
   wdpc_core_model u_core (.aclk(aclk), .cpu_clk_en(cpu_clk_en), .osc_en(osc_en),
      .instr_valid(instr_valid), .instr_opcode(instr_opcode), .irq_req(irq_req),
      .osc_tick(osc_tick), .recovery_input_pin(recovery_input_pin));
   initial begin
      forever #12.5 aclk = ~aclk;
   end
   task automatic give_verdict();
      if (mismatches == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
      chk({30'h0, got}, {30'h0, exp});
   endtask : chk_rsp
   task automatic wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] r);
      int t;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, v};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (t = 0; t < 64; t++) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      r = bresp;
      bready <= 1'b0;
      if (t == 64) mismatches++;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
      int t;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (t = 0; t < 64; t++) begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      v = rdata;
      r = rresp;
      rready <= 1'b0;
      if (t == 64) mismatches++;
   endtask : rd
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
      rd(a, d, rsp);
      chk(d, {24'h0, exp});
   endtask : rd_chk
   // Restart pulse must (or must not) appear between lo and hi cycles from now
   task automatic wait_rst(input int lo, input int hi, input logic exp);
      int n;
      logic seen;
      seen = 1'b0;
      for (n = 0; n < hi && !seen; n++) begin
         @(posedge aclk);
         seen = (restart_req === 1'b1);
      end
      chk({31'h0, seen && n >= lo}, {31'h0, exp});
   endtask : wait_rst
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
   endtask : do_reset
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      give_verdict();
   end
   initial begin
      do_reset();
      rd_chk(A_CTRL, 8'h98);
      rd_chk(A_STAT, 8'h04);
      rd(12'h300, d, rsp);
      chk_rsp(rsp, `WDPC_RESP_ERR);
      wr(12'h300, 8'h01, rsp);
      chk_rsp(rsp, `WDPC_RESP_ERR);
      wr(A_CTRL, 8'h10, rsp);
      rd_chk(A_CTRL, 8'h10);
      u_core.exec(`WDPC_OP_REFRESH);
      wr(A_CTRL, 8'h88, rsp);
      chk_rsp(rsp, `WDPC_RESP_OK);
      rd_chk(A_CTRL, 8'h10);
      rd_chk(A_STAT, 8'h00);
      repeat (500) @(posedge aclk);
      u_core.exec(`WDPC_OP_REFRESH);
      wait_rst(TO1 - 8, TO1 + 8, 1'b1);
      chk({16'h0, restart_addr}, {16'h0, `WDPC_RESTART});
      rd_chk(A_STAT, 8'h01);
      rd_chk(A_STAT, 8'h01);
      wr(A_STAT, 8'h01, rsp);
      rd_chk(A_STAT, 8'h00);
      u_core.exec(`WDPC_OP_REFRESH);
      u_core.exec(`WDPC_OP_HALT);
      repeat (3) @(posedge aclk);
      chk({30'h0, cpu_clk_en, osc_en}, 32'h1);
      wait_rst(0, TO1 + 100, 1'b0);
      u_core.irq();
      wait_rst(0, 20, 1'b0);
      chk({31'h0, cpu_clk_en}, 32'h1);
      u_core.exec(`WDPC_OP_REFRESH);
      u_core.exec(`WDPC_OP_STOP);
      repeat (3) @(posedge aclk);
      chk({31'h0, osc_en}, 32'h0);
      rd_chk(A_STAT, 8'h0A);
      wait_rst(0, TO1 + 100, 1'b0);
      fork
         u_core.wake();
         wait_rst(0, 40, 1'b1);
      join
      repeat (2) @(posedge aclk);
      chk({30'h0, cpu_clk_en, osc_en}, 32'h3);
      rd_chk(A_CTRL, 8'h10);
      rd_chk(A_STAT, 8'h02);
      do_reset();
      rd_chk(A_STAT, 8'h04);
      wr(A_CTRL, 8'h88, rsp);
      rd_chk(A_CTRL, 8'h88);
      u_core.exec(`WDPC_OP_STOP);
      repeat (3) @(posedge aclk);
      chk({30'h0, cpu_clk_en, osc_en}, 32'h3);
      rd_chk(A_STAT, 8'h00);
      wait_rst(0, TO1 + 100, 1'b0);
      do_reset();
      u_core.exec(`WDPC_OP_REFRESH);
      u_core.exec(`WDPC_OP_HALT);
      // Frozen cycles must push the timeout back by as many cycles
      ce <= 1'b0;
      repeat (50) @(posedge aclk);
      ce <= 1'b1;
      wait_rst(TO1 - 8, TO1 + 8, 1'b1);
      chk({31'h0, cpu_clk_en}, 32'h1);
      rd_chk(A_STAT, 8'h01);
      give_verdict();
   end
endmodule : tb_top
